/* File: logic/dpg_gpio.sv */
`timescale 1ns/100ps
module dpg_gpio #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic                   pready_o,
    output logic      [31:0]       prdata_o,
    output logic                   pslverr_o,
    input  wire logic [7:0]        porta_pin_i,
    output logic      [7:0]        porta_out_o,
    output logic      [7:0]        porta_oe_o,
    output logic      [7:0]        porta_pullup_o,
    input  wire logic [7:0]        portb_pin_i,
    input  wire logic [7:0]        portb_dir_i,
    output logic      [7:0]        portb_out_o,
    output logic      [7:0]        portb_oe_o,
    output logic                   irq_o,
    output logic                   wake_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] pa_s1_q, pa_s2_q, pa_old_q;
    logic [7:0] pb_s1_q, pb_s2_q, pb_old_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_s1_q  <= dpg_pkg::RST_ZERO;
            pa_s2_q  <= dpg_pkg::RST_ZERO;
            pa_old_q <= dpg_pkg::RST_ZERO;
            pb_s1_q  <= dpg_pkg::RST_ZERO;
            pb_s2_q  <= dpg_pkg::RST_ZERO;
            pb_old_q <= dpg_pkg::RST_ZERO;
        end else begin
            pa_s1_q  <= porta_pin_i;
            pa_s2_q  <= pa_s1_q;
            pa_old_q <= pa_s2_q;
            pb_s1_q  <= portb_pin_i;
            pb_s2_q  <= pb_s1_q;
            pb_old_q <= pb_s2_q;
        end
    end

    // ------------------------------------------------------------
    // edge events
    // ------------------------------------------------------------
    logic [7:0] pa_tog, pb_tog;
    logic       pa_rise, pa_fall, pb_rise, pb_fall;
    logic [1:0] pa_sel, pb_sel;
    logic       pa_hit, pb_hit;
    logic [3:0] edge_q;
    logic [7:0] pa_wake_q, pb_wake_q;

    // toggles compare the two settled stages only
    assign pa_tog  = pa_s2_q ^ pa_old_q;
    assign pb_tog  = pb_s2_q ^ pb_old_q;
    assign pa_rise = pa_tog[dpg_pkg::PIN0] & pa_s2_q[dpg_pkg::PIN0];
    assign pa_fall = pa_tog[dpg_pkg::PIN0] & ~pa_s2_q[dpg_pkg::PIN0];
    assign pb_rise = pb_tog[dpg_pkg::PIN0] & pb_s2_q[dpg_pkg::PIN0];
    assign pb_fall = pb_tog[dpg_pkg::PIN0] & ~pb_s2_q[dpg_pkg::PIN0];
    assign pa_sel  = edge_q[dpg_pkg::EDGE_PA_LSB +: 2];
    assign pb_sel  = edge_q[dpg_pkg::EDGE_PB_LSB +: 2];

    // code 11 is reserved and raises nothing
    function automatic logic edge_match(input logic [1:0] sel, input logic r,
                                        input logic f);
        logic m;
        m = 1'b0;
        case (sel)
            dpg_pkg::EDGE_BOTH: m = r | f;
            dpg_pkg::EDGE_RISE: m = r;
            dpg_pkg::EDGE_FALL: m = f;
            default:            m = 1'b0;
        endcase
        return m;
    endfunction : edge_match

    // port A pin 0 requests need its wake enable bit
    assign pa_hit = edge_match(pa_sel, pa_rise, pa_fall)
                    & pa_wake_q[dpg_pkg::PIN0];
    assign pb_hit = edge_match(pb_sel, pb_rise, pb_fall);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic       setup, access, wr, hit_ok;
    logic [7:0] idx;

    assign setup  = psel_i & ~penable_i;
    assign access = psel_i & penable_i;
    assign wr     = access & pwrite_i & ~pslverr_o;
    assign idx    = paddr_i[9:2];
    // upper and lane bits must be zero, else unmapped
    assign hit_ok = (paddr_i[1:0] == 2'h0) && (paddr_i >> 10 == '0);
    // answer after the setup cycle: one access cycle, never stalls
    assign pready_o = access;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] pa_data_q, pa_data_d, pa_dir_q, pa_dir_d;
    logic [7:0] pa_pull_q, pa_pull_d, pb_data_q, pb_data_d;
    logic [7:0] pa_wake_d, pb_wake_d;
    logic [3:0] edge_d;
    logic [1:0] int_en_q, int_en_d, int_req_q, int_req_d;
    logic [31:0] rdata_d;
    logic       err_d, irq_d, wake_d;
    logic [7:0] pa_view, pb_view;

    // input pins read their level, output pins their latch
    assign pa_view = (pa_data_q & pa_dir_q) | (pa_s2_q & ~pa_dir_q);
    assign pb_view = (pb_data_q & portb_dir_i) | (pb_s2_q & ~portb_dir_i);

    // next state for all software registers
    always_comb begin
        pa_data_d = pa_data_q;
        pa_dir_d  = pa_dir_q;
        pa_pull_d = pa_pull_q;
        pb_data_d = pb_data_q;
        pa_wake_d = pa_wake_q;
        pb_wake_d = pb_wake_q;
        edge_d    = edge_q;
        int_en_d  = int_en_q;
        int_req_d = int_req_q;
        if (wr) begin
            if (idx == dpg_pkg::IDX_PA_DATA) begin
                pa_data_d = pwdata_i[7:0];
            end else if (idx == dpg_pkg::IDX_PA_DIR) begin
                pa_dir_d = pwdata_i[7:0];
            end else if (idx == dpg_pkg::IDX_PA_PULL) begin
                pa_pull_d = pwdata_i[7:0];
            end else if (idx == dpg_pkg::IDX_PB_DATA) begin
                pb_data_d = pwdata_i[7:0];
            end else if (idx == dpg_pkg::IDX_PA_WAKE) begin
                pa_wake_d = pwdata_i[7:0] & dpg_pkg::PA_WAKE_MASK;
            end else if (idx == dpg_pkg::IDX_PB_WAKE) begin
                pb_wake_d = pwdata_i[7:0];
            end else if (idx == dpg_pkg::IDX_EDGE_SEL) begin
                edge_d = pwdata_i[3:0];
            end else if (idx == dpg_pkg::IDX_INT_EN) begin
                int_en_d = pwdata_i[1:0];
            end else if (idx == dpg_pkg::IDX_INT_REQ) begin
                int_req_d = pwdata_i[1:0];
            end
        end
        // hardware set wins over a software clear
        int_req_d[dpg_pkg::IRQ_PA] = int_req_d[dpg_pkg::IRQ_PA] | pa_hit;
        int_req_d[dpg_pkg::IRQ_PB] = int_req_d[dpg_pkg::IRQ_PB] | pb_hit;
    end

    // read data and error latched in the setup cycle
    always_comb begin
        rdata_d = prdata_o;
        err_d   = pslverr_o;
        if (setup) begin
            rdata_d = '0;
            err_d   = 1'b0;
            if (!hit_ok) begin
                err_d = 1'b1;
            end else if (idx == dpg_pkg::IDX_PA_DATA) begin
                rdata_d[7:0] = pa_view;
            end else if (idx == dpg_pkg::IDX_PA_DIR) begin
                rdata_d[7:0] = pa_dir_q;
            end else if (idx == dpg_pkg::IDX_PA_PULL) begin
                rdata_d[7:0] = pa_pull_q;
            end else if (idx == dpg_pkg::IDX_PB_DATA) begin
                rdata_d[7:0] = pb_view;
            end else if (idx == dpg_pkg::IDX_INT_EN) begin
                rdata_d[1:0] = int_en_q;
            end else if (idx == dpg_pkg::IDX_INT_REQ) begin
                rdata_d[1:0] = int_req_q;
            end else if (idx == dpg_pkg::IDX_PA_WAKE || idx == dpg_pkg::IDX_PB_WAKE
                         || idx == dpg_pkg::IDX_EDGE_SEL) begin
                rdata_d = '0;  // write-only, reads zero
            end else begin
                err_d = 1'b1;
            end
        end
    end

    // wake needs an enabled toggle; port A pins 2..1 never wake
    assign wake_d = |(pa_tog & pa_wake_q) | |(pb_tog & pb_wake_q);
    assign irq_d  = |(int_req_d & int_en_d);

    // registered state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_data_q <= dpg_pkg::RST_ZERO;
            pa_dir_q  <= dpg_pkg::RST_ZERO;
            pa_pull_q <= dpg_pkg::RST_ZERO;
            pb_data_q <= dpg_pkg::RST_ZERO;
            pa_wake_q <= dpg_pkg::RST_PA_WAKE;
            pb_wake_q <= dpg_pkg::RST_PB_WAKE;
            edge_q    <= dpg_pkg::RST_EDGE;
            int_en_q  <= dpg_pkg::RST_IRQ;
            int_req_q <= dpg_pkg::RST_IRQ;
            prdata_o  <= '0;
            pslverr_o <= 1'b0;
            irq_o     <= 1'b0;
            wake_o    <= 1'b0;
        end else begin
            pa_data_q <= pa_data_d;
            pa_dir_q  <= pa_dir_d;
            pa_pull_q <= pa_pull_d;
            pb_data_q <= pb_data_d;
            pa_wake_q <= pa_wake_d;
            pb_wake_q <= pb_wake_d;
            edge_q    <= edge_d;
            int_en_q  <= int_en_d;
            int_req_q <= int_req_d;
            prdata_o  <= rdata_d;
            pslverr_o <= err_d;
            irq_o     <= irq_d;
            wake_o    <= wake_d;
        end
    end

    // pins driven straight from the latches; port B enable comes from portb_dir_i
    assign porta_out_o    = pa_data_q;
    assign porta_oe_o     = pa_dir_q;
    assign porta_pullup_o = pa_pull_q;
    assign portb_out_o    = pb_data_q;
    assign portb_oe_o     = portb_dir_i;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic wr_dir, wr_pull, wr_pa, wr_pb, wr_req;
    assign wr_dir  = wr && idx == dpg_pkg::IDX_PA_DIR;
    assign wr_pull = wr && idx == dpg_pkg::IDX_PA_PULL;
    assign wr_pa   = wr && idx == dpg_pkg::IDX_PA_DATA;
    assign wr_pb   = wr && idx == dpg_pkg::IDX_PB_DATA;
    assign wr_req  = wr && idx == dpg_pkg::IDX_INT_REQ;

    property p_dir;
        @(posedge clk_i) disable iff (rst_i)
        wr_dir |=> porta_oe_o == $past(pwdata_i[7:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction write lost");

    property p_pull_rst;
        @(posedge clk_i) $fell(rst_i) |-> porta_pullup_o == 8'h00 && porta_oe_o == 8'h00;
    endproperty
    a_pull_rst: assert property (p_pull_rst) else $error("pull or dir not reset");

    property p_pull;
        @(posedge clk_i) disable iff (rst_i)
        wr_pull |=> porta_pullup_o == $past(pwdata_i[7:0]);
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up write lost");

    property p_pa;
        @(posedge clk_i) disable iff (rst_i)
        wr_pa |=> porta_out_o == $past(pwdata_i[7:0]);
    endproperty
    a_pa: assert property (p_pa) else $error("port A data write lost");

    property p_pb;
        @(posedge clk_i) disable iff (rst_i)
        wr_pb ##1 !wr_pb |=> portb_out_o == $past(pwdata_i[7:0], 2);
    endproperty
    a_pb: assert property (p_pb) else $error("port B data write lost");

    property p_wake;
        @(posedge clk_i) disable iff (rst_i)
        wake_o |-> $past(|(pa_tog & pa_wake_q) || |(pb_tog & pb_wake_q));
    endproperty
    a_wake: assert property (p_wake) else $error("wake without enabled toggle");

    property p_pa0_block;
        @(posedge clk_i) disable iff (rst_i)
        !pa_wake_q[0] && !wr_req && !int_req_q[0] |=> !int_req_q[0];
    endproperty
    a_pa0_block: assert property (p_pa0_block) else $error("blocked pin 0 request");

    property p_rise_only;
        @(posedge clk_i) disable iff (rst_i)
        pa_sel == dpg_pkg::EDGE_RISE && pa_fall && !wr_req && !int_req_q[0]
        |=> !int_req_q[0];
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("fall raised request");

    property p_req_set;
        @(posedge clk_i) disable iff (rst_i)
        pb_hit |=> int_req_q[1];
    endproperty
    a_req_set: assert property (p_req_set) else $error("port B request missed");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        int_req_q[0] && int_en_q[0] |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled request not forwarded");

    property p_sync;
        @(posedge clk_i) disable iff (rst_i)
        $changed(porta_pin_i[0]) ##1 $stable(porta_pin_i[0]) ##1 1'b1
        |-> pa_s2_q[0] == $past(porta_pin_i[0], 2);
    endproperty
    a_sync: assert property (p_sync) else $error("pin not seen after two edges");

    c_pa_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(int_req_q[0]));
    c_pb_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(int_req_q[1]));
    c_wake:   cover property (@(posedge clk_i) disable iff (rst_i) wake_o);
    c_err:    cover property (@(posedge clk_i) disable iff (rst_i) pready_o && pslverr_o);
endmodule : dpg_gpio

/* File: logic/dpg_pkg.sv */
package dpg_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_INT_EN   = 8'h04;
    localparam logic [7:0] IDX_INT_REQ  = 8'h05;
    localparam logic [7:0] IDX_EDGE_SEL = 8'h0C;
    localparam logic [7:0] IDX_PA_WAKE  = 8'h0D;
    localparam logic [7:0] IDX_PB_WAKE  = 8'h0E;
    localparam logic [7:0] IDX_PA_DATA  = 8'h10;
    localparam logic [7:0] IDX_PA_DIR   = 8'h11;
    localparam logic [7:0] IDX_PA_PULL  = 8'h12;
    localparam logic [7:0] IDX_PB_DATA  = 8'h14;

    // ------------------------------------------------------------
    // reset values and field layouts
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_PA_WAKE  = 8'hF9;
    localparam logic [7:0] RST_PB_WAKE  = 8'hFF;
    localparam logic [7:0] PA_WAKE_MASK = 8'hF9;
    localparam logic [3:0] RST_EDGE     = 4'h0;
    localparam logic [1:0] RST_IRQ      = 2'h0;
    localparam int         EDGE_PA_LSB  = 0;
    localparam int         EDGE_PB_LSB  = 2;
    localparam int         IRQ_PA       = 0;
    localparam int         IRQ_PB       = 1;
    localparam int         PIN0         = 0;

    // ------------------------------------------------------------
    // edge selection codes
    // ------------------------------------------------------------
    localparam logic [1:0] EDGE_BOTH    = 2'h0;
    localparam logic [1:0] EDGE_RISE    = 2'h1;
    localparam logic [1:0] EDGE_FALL    = 2'h2;
endpackage : dpg_pkg

/* File: bench/dpg_board.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// board side of both ports: drivers, port A pull-ups, floating wires
// ----------------------------------------------------------------
module dpg_board (
    input  wire logic       clk_i,
    input  wire logic [7:0] a_out_i,
    input  wire logic [7:0] a_oe_i,
    input  wire logic [7:0] a_pull_i,
    input  wire logic [7:0] a_ext_en_i,
    input  wire logic [7:0] a_ext_val_i,
    input  wire logic [7:0] b_out_i,
    input  wire logic [7:0] b_oe_i,
    input  wire logic [7:0] b_ext_en_i,
    input  wire logic [7:0] b_ext_val_i,
    output logic      [7:0] a_lvl_o,
    output logic      [7:0] b_lvl_o
);
    logic [7:0] hold_a = 8'h00;
    logic [7:0] hold_b = 8'h00;

    // a floating wire shows the inverse of its last driven level,
    // so the simulator never settles it to a lucky value
    function automatic logic [7:0] wire_lvl(input logic [7:0] oe, out, en, val, pull, hold);
        return (oe & out) | (~oe & en & val) | (~oe & ~en & (pull | ~hold));
    endfunction : wire_lvl

    assign a_lvl_o = wire_lvl(a_oe_i, a_out_i, a_ext_en_i, a_ext_val_i, a_pull_i, hold_a);
    assign b_lvl_o = wire_lvl(b_oe_i, b_out_i, b_ext_en_i, b_ext_val_i, 8'h00, hold_b);

    // remember levels only while something drives the wire
    always @(posedge clk_i) begin
        hold_a <= (a_lvl_o & (a_oe_i | a_ext_en_i)) | (hold_a & ~(a_oe_i | a_ext_en_i));
        hold_b <= (b_lvl_o & (b_oe_i | b_ext_en_i)) | (hold_b & ~(b_oe_i | b_ext_en_i));
    end
endmodule : dpg_board

/* File: bench/tb.sv */
`timescale 1ns/100ps
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [7:0]  portb_dir_i = 8'h00;
    logic [7:0]  a_en = 8'hFF, a_val = 8'h00, b_en = 8'hFF, b_val = 8'h00;
    logic [7:0]  porta_pin_i, porta_out_o, porta_oe_o, porta_pullup_o;
    logic [7:0]  portb_pin_i, portb_out_o, portb_oe_o;
    logic [31:0] prdata_o, rd;
    logic        pready_o, pslverr_o, irq_o, wake_o, err;
    int          failures = 0, checked = 0, wakes = 0;
    logic [7:0]  rst_idx [6] = '{dpg_pkg::IDX_PA_DATA, dpg_pkg::IDX_PA_DIR, dpg_pkg::IDX_PA_PULL,
                                 dpg_pkg::IDX_PB_DATA, dpg_pkg::IDX_INT_EN, dpg_pkg::IDX_INT_REQ};

    dpg_gpio uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o), .porta_pin_i(porta_pin_i),
        .porta_out_o(porta_out_o), .porta_oe_o(porta_oe_o), .porta_pullup_o(porta_pullup_o),
        .portb_pin_i(portb_pin_i), .portb_dir_i(portb_dir_i), .portb_out_o(portb_out_o),
        .portb_oe_o(portb_oe_o), .irq_o(irq_o), .wake_o(wake_o));

    dpg_board board (.clk_i(clk_i), .a_out_i(porta_out_o), .a_oe_i(porta_oe_o),
        .a_pull_i(porta_pullup_o), .a_ext_en_i(a_en), .a_ext_val_i(a_val),
        .b_out_i(portb_out_o), .b_oe_i(portb_oe_o), .b_ext_en_i(b_en), .b_ext_val_i(b_val),
        .a_lvl_o(porta_pin_i), .b_lvl_o(portb_pin_i));

    // clock and wake pulse counter
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (wake_o === 1'b1) wakes <= wakes + 1;

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i} <= {1'b1, 1'b0, wr};
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            tally_and_finish();
        end
        rd = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask : apb

    // set board levels, let synchronisers settle, count wake pulses
    task automatic wake_chk(input logic [7:0] a, input logic [7:0] b, input int exp);
        int w0;
        w0 = wakes;
        a_val <= a;
        b_val <= b;
        repeat (10) @(posedge clk_i);
        chk(32'(wakes - w0), 32'(exp));
    endtask : wake_chk

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        foreach (rst_idx[i]) begin
            apb(1'b0, rst_idx[i], 32'h0);
            chk(rd, 32'h0);
        end
        chk({porta_oe_o, porta_pullup_o}, 16'h0000);
        // port A mixed direction with pull-up on a released pin
        a_en <= 8'h70;
        a_val <= 8'h30;
        apb(1'b1, dpg_pkg::IDX_PA_DIR, 32'h0F);
        apb(1'b1, dpg_pkg::IDX_PA_DATA, 32'hA5);
        apb(1'b1, dpg_pkg::IDX_PA_PULL, 32'h80);
        repeat (4) @(posedge clk_i);
        apb(1'b0, dpg_pkg::IDX_PA_DATA, 32'h0);
        chk(rd, 32'hB5);
        chk({porta_out_o, porta_oe_o, porta_pullup_o}, 24'hA50F80);
        apb(1'b0, dpg_pkg::IDX_PA_DIR, 32'h0);
        chk(rd, 32'h0F);
        // port B driven from its own latch
        b_en <= 8'h00;
        portb_dir_i <= 8'hFF;
        apb(1'b1, dpg_pkg::IDX_PB_DATA, 32'h5A);
        repeat (4) @(posedge clk_i);
        apb(1'b0, dpg_pkg::IDX_PB_DATA, 32'h0);
        chk({rd[7:0], portb_out_o, portb_oe_o}, 24'h5A5AFF);
        // unmapped index refused, write-only reads zero
        apb(1'b1, 8'h13, 32'hFF);
        apb(1'b0, 8'h13, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, dpg_pkg::IDX_EDGE_SEL, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h0);
        // quiet all pins again: everything inputs, board drives zero
        portb_dir_i <= 8'h00;
        {a_en, a_val, b_en, b_val} <= 32'hFF00FF00;
        apb(1'b1, dpg_pkg::IDX_PA_DIR, 32'h0);
        apb(1'b1, dpg_pkg::IDX_PA_PULL, 32'h0);
        repeat (10) @(posedge clk_i);
        // wake enables at their reset values, then narrowed
        // toggles landing in one cycle give a single wake pulse
        wake_chk(8'h80, 8'h00, 1);
        wake_chk(8'h82, 8'h00, 0);
        wake_chk(8'h00, 8'h08, 1);
        wake_chk(8'h01, 8'h00, 1);
        wake_chk(8'h00, 8'h00, 1);
        apb(1'b1, dpg_pkg::IDX_PB_WAKE, 32'hF7);
        apb(1'b1, dpg_pkg::IDX_PA_WAKE, 32'h08);
        // clear before the blocked pin 0 edges so they are really tested
        apb(1'b1, dpg_pkg::IDX_INT_REQ, 32'h0);
        wake_chk(8'h00, 8'h08, 0);
        wake_chk(8'h11, 8'h00, 0);
        wake_chk(8'h18, 8'h00, 1);
        wake_chk(8'h00, 8'h00, 1);
        apb(1'b0, dpg_pkg::IDX_INT_REQ, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, dpg_pkg::IDX_PA_WAKE, 32'hF9);
        // every edge code on both pin-0 sources
        apb(1'b1, dpg_pkg::IDX_INT_EN, 32'h3);
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                apb(1'b1, dpg_pkg::IDX_EDGE_SEL, 32'(c) << (2 * p));
                apb(1'b1, dpg_pkg::IDX_INT_REQ, 32'h0);
                wake_chk(8'(p == 0), 8'(p == 1), 1);
                apb(1'b0, dpg_pkg::IDX_INT_REQ, 32'h0);
                chk(rd, 32'(c < 2) << p);
                chk(32'(irq_o), 32'(c < 2));
                apb(1'b1, dpg_pkg::IDX_INT_REQ, 32'h0);
                wake_chk(8'h00, 8'h00, 1);
                apb(1'b0, dpg_pkg::IDX_INT_REQ, 32'h0);
                chk(rd, 32'(c == 0 || c == 2) << p);
            end
        end
        // request held but not forwarded while its enable is off
        apb(1'b1, dpg_pkg::IDX_EDGE_SEL, 32'h0);
        apb(1'b1, dpg_pkg::IDX_INT_EN, 32'h2);
        wake_chk(8'h01, 8'h00, 1);
        apb(1'b0, dpg_pkg::IDX_INT_REQ, 32'h0);
        chk(rd, 32'h1);
        chk(32'(irq_o), 32'h0);
        apb(1'b1, dpg_pkg::IDX_INT_EN, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        tally_and_finish();
    end
endmodule : tb
